// File: verilog/apmc_pkg.sv
// Shared constants and types for the amplifier protection and mode control ends
`default_nettype none
package apmc_pkg;

  // Clock and latch-reset timing
  localparam int CLK_PERIOD_NS  = 50;                     // 20 MHz system clock
  localparam int LATCH_CLR_NS   = 200;                    // Least low time to clear latch
  localparam int LATCH_CLR_CYC  = (LATCH_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_PULSE_CYC = LATCH_CLR_CYC + 2;      // Host pulse with margin

  // Ramp timing
  localparam int RAMP_TICK_DEF  = 16;                     // Cycles per ramp step
  localparam int HOST_PWRUP_DEF = 64;                     // Host wait before power-up pulse

  // Model of the mode-control pin voltage, full scale is the analog supply
  localparam int         VW        = 10;                  // Voltage code width
  localparam logic [9:0] V_ZERO    = 10'h000;             // Pin fully discharged
  localparam logic [9:0] V_FULL    = 10'h3FF;             // Pin at analog supply
  localparam logic [9:0] V_UPPER   = 10'h2CC;             // Upper threshold code
  localparam logic [9:0] V_LOWER   = 10'h0CC;             // Lower threshold code
  localparam logic [9:0] STEP_SU   = 10'h007;             // Start-up ramp step, 0.7 scaled
  localparam logic [9:0] STEP_RST  = 10'h00B;             // Recycle ramp step, 1.1 scaled

  // Bit positions of the synchronised analog event vector
  localparam int IN_OC_HS  = 0;                           // High-side overcurrent
  localparam int IN_OC_LS  = 1;                           // Low-side overcurrent
  localparam int IN_OT     = 2;                           // Over-temperature input
  localparam int IN_TJ     = 3;                           // Junction thermal shutdown
  localparam int IN_DC     = 4;                           // DC offset protection
  localparam int IN_AA_OK  = 5;                           // Analog supply above lockout
  localparam int IN_VCC_OK = 6;                           // Low-side gate supply ok
  localparam int IN_BS_OK  = 7;                           // Bootstrap supply ok
  localparam int IN_W      = 8;                           // Vector width
  // Synchroniser reset: supplies read as ok, so reset fakes no recovery edge
  localparam logic [7:0] SYNC_RST = 8'hE0;                // Ok bits set, events clear

  // Reset values
  localparam logic       SD_LATCH_RST = 1'b1;             // Latch starts in shutdown

  // Recycle sequencer states
  typedef enum logic [1:0] {RC_IDLE, RC_DISCH, RC_CHARGE} apmc_rc_t;

endpackage
`default_nettype wire

// File: verilog/apmc_mode_if.sv
// Mode-control pin carrier between the amplifier end and the system controller end
`timescale 1ns/10ps
`default_nettype none
interface apmc_mode_if;
  logic       dev_sink_oe;   // Amplifier sinks current on the pin
  logic       host_pull_oe;  // Controller transistor pulls the pin low
  logic [9:0] pin_level;     // Modelled pin voltage, driven by the amplifier
  logic       pin_low;       // Resolved wire: someone pulls the pin

  // Open-drain wire: low whenever either party drives
  assign pin_low = dev_sink_oe | host_pull_oe;

  modport device (output dev_sink_oe, output pin_level, input host_pull_oe, input pin_low);
  modport host   (output host_pull_oe, input dev_sink_oe, input pin_level, input pin_low);
endinterface
`default_nettype wire

// File: verilog/apmc_device.sv
// Amplifier end: mode selection, shutdown latch, recycle timer and fault flag
`timescale 1ns/10ps
`default_nettype none
// Function
// [R1] Pin below lower threshold: full shutdown
// [R2] Between thresholds: outputs off, prebias oscillation
// [R3] Above upper threshold: normal PWM operation
// [R4] Switching starts only with all supplies ok
// [R5] Gate supply recovery triggers recycle, fault low
// [R6] Overcurrent keeps recycling, fault low meanwhile
// [R7] DC fault holds pin and fault low
// [R8] Over-temperature input keeps recycling, fault low
// [R9] Either overcurrent sensor sets shutdown latch
// [R10] Self-reset: discharge, clear latch, charge, resume
// [R11] Persistent overcurrent repeats the whole sequence
// [R12] Host pull below upper forces shutdown
// [R13] Latched: host low 200 ns clears latch
// [R14] Latched: stays shut after power-up until pulse
// [R15] Sink pin current during protection events
// [R16] Junction overheat stops PWM switching
// [R17] Gate supply low turns both outputs off
// [R18] Bootstrap low disables only high side
// [R19] Ramp steps scale with 1.1 and 0.7
// [R20] Host ramps pin slowly enough for precharge
// [R21] Host sizes capacitor for 0.1 s interval
// [R22] Fault released only in normal operation
// [R23] Static input selects self-reset or latched
module apmc_device #(
  parameter int RAMP_TICK = apmc_pkg::RAMP_TICK_DEF   // Cycles per ramp step
) (
  input  wire logic     i_clk_sys,      // System clock
  input  wire logic     i_rst_n,        // Async reset, active low
  input  wire logic     i_cfg_latched,  // 1 latched, 0 self-reset
  input  wire logic     i_oc_hs,        // High-side overcurrent sensor
  input  wire logic     i_oc_ls,        // Low-side overcurrent sensor
  input  wire logic     i_ot_evt,       // Over-temperature input
  input  wire logic     i_tj_hot,       // Junction over thermal limit
  input  wire logic     i_dc_fault,     // DC offset protection
  input  wire logic     i_aa_ok,        // Analog supplies above lockout
  input  wire logic     i_vcc_ok,       // Low-side gate supply ok
  input  wire logic     i_bs_ok,        // Bootstrap supply ok
  input  wire logic     i_pwm_hs,       // Modulator high-side request
  input  wire logic     i_pwm_ls,       // Modulator low-side request
  apmc_mode_if.device   mode,           // Mode-control pin
  output logic          o_ota_en,       // Input amplifier enabled
  output logic          o_prebias_osc,  // Local prebias oscillation on
  output logic          o_pwm_run,      // PWM switching allowed
  output logic          o_hs_on,        // High-side transistor gate
  output logic          o_ls_on,        // Low-side transistor gate
  output logic          o_fault_oe,     // Fault flag pulled low
  output logic          o_sd_latched    // Shutdown latch state
);

  // Synchroniser stages and derived event levels
  logic [apmc_pkg::IN_W-1:0] sync1_q;       // First stage, read only by second
  logic [apmc_pkg::IN_W-1:0] sync2_q;       // Second stage, safe to use
  logic                      vcc_prev_q;    // Previous gate supply level
  logic [15:0]               tick_cnt_q;    // Ramp divider
  logic                      tick;          // One-cycle ramp enable
  logic [apmc_pkg::VW-1:0]   v_q;           // Modelled pin voltage
  logic [apmc_pkg::VW-1:0]   step;          // Current charge step
  logic [3:0]                low_cnt_q;     // Host low duration, latched mode
  logic                      sd_latch_q;    // Shutdown latch
  logic                      sink_q;        // Pin sink drive
  logic                      run_q;         // Switching running
  apmc_pkg::apmc_rc_t        rc_q;          // Recycle sequencer
  logic                      above_upper;   // Upper comparator
  logic                      below_lower;   // Lower comparator
  logic                      oc_any;        // Either sensor trips
  logic                      vcc_rise;      // Gate supply recovered
  logic                      normal_ok;     // All conditions for normal mode
  logic                      run_d;         // Next running state

  // Analog comparator outputs are asynchronous, so all pass two flops
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_q <= apmc_pkg::SYNC_RST;
      sync2_q <= apmc_pkg::SYNC_RST;
    end
    else
    begin
      sync1_q <= {i_bs_ok, i_vcc_ok, i_aa_ok, i_dc_fault,
                  i_tj_hot, i_ot_evt, i_oc_ls, i_oc_hs};
      sync2_q <= sync1_q;
    end
  end

  // Edge memory for the gate supply recovery
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      vcc_prev_q <= 1'b1;                                      // Idle level, no false rise
    else
      vcc_prev_q <= sync2_q[apmc_pkg::IN_VCC_OK];
  end

  assign vcc_rise    = sync2_q[apmc_pkg::IN_VCC_OK] & ~vcc_prev_q;  // [R5]
  assign oc_any      = sync2_q[apmc_pkg::IN_OC_HS] | sync2_q[apmc_pkg::IN_OC_LS];
  assign above_upper = (v_q > apmc_pkg::V_UPPER);
  assign below_lower = (v_q < apmc_pkg::V_LOWER);

  // Ramp divider stands in for the slow capacitor current
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tick_cnt_q <= '0;
    else if (tick)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 16'h0001;
  end

  assign tick = (tick_cnt_q == 16'(RAMP_TICK - 1));

  // Recycle charge is faster than first start-up charge
  assign step = (rc_q != apmc_pkg::RC_IDLE) ? apmc_pkg::STEP_RST : apmc_pkg::STEP_SU;  // [R19]

  // Pin voltage model; a stiff pull-up in latched mode follows the host only
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      v_q <= apmc_pkg::V_ZERO;
    else if (i_cfg_latched)                                    // [R23]
      v_q <= mode.host_pull_oe ? apmc_pkg::V_ZERO : apmc_pkg::V_FULL;
    else if (tick)
    begin
      if (mode.pin_low)                                        // Discharge
        v_q <= (v_q > apmc_pkg::STEP_RST) ? v_q - apmc_pkg::STEP_RST : apmc_pkg::V_ZERO;
      else                                                     // Charge, saturating
        v_q <= ((apmc_pkg::V_FULL - v_q) > step) ? v_q + step : apmc_pkg::V_FULL;  // [R19]
    end
  end

  // Count how long the host holds the pin low, saturating
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      low_cnt_q <= '0;
    else if (!mode.host_pull_oe)
      low_cnt_q <= '0;
    else if (low_cnt_q != 4'hF)
      low_cnt_q <= low_cnt_q + 4'h1;
  end

  // Shutdown latch; a trip in the clearing cycle wins over the clear
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sd_latch_q <= apmc_pkg::SD_LATCH_RST;                    // [R14]
    else if (oc_any)
      sd_latch_q <= 1'b1;                                      // [R9]
    else if (i_cfg_latched && (low_cnt_q >= 4'(apmc_pkg::LATCH_CLR_CYC)))
      sd_latch_q <= 1'b0;                                      // [R13]
    else if (!i_cfg_latched && below_lower)
      sd_latch_q <= 1'b0;                                      // [R10]
  end

  // Recycle sequencer, only meaningful with a timing capacitor
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rc_q <= apmc_pkg::RC_IDLE;
    else if (i_cfg_latched)
      rc_q <= apmc_pkg::RC_IDLE;
    else
    begin
      case (rc_q)
        apmc_pkg::RC_IDLE:
          // Latched overcurrent above upper, over-temperature input or gate supply recovery starts a discharge
          if ((sd_latch_q && above_upper) || sync2_q[apmc_pkg::IN_OT] || vcc_rise)
            rc_q <= apmc_pkg::RC_DISCH;                        // [R5] [R6] [R8]
        apmc_pkg::RC_DISCH:
          if (below_lower)
            rc_q <= apmc_pkg::RC_CHARGE;                       // [R10]
        apmc_pkg::RC_CHARGE:
          // Persisting faults restart the discharge
          if (sd_latch_q || sync2_q[apmc_pkg::IN_OT])
            rc_q <= apmc_pkg::RC_DISCH;                        // [R11] [R8]
          else if (above_upper)
            rc_q <= apmc_pkg::RC_IDLE;                         // [R10]
        default:
          rc_q <= apmc_pkg::RC_IDLE;
      endcase
    end
  end

  // Sink current marks protection for the host detector
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sink_q <= 1'b0;
    else
      sink_q <= (rc_q == apmc_pkg::RC_DISCH)                   // [R15]
              | sync2_q[apmc_pkg::IN_DC]                       // [R7]
              | (i_cfg_latched & sd_latch_q);                  // [R15]
  end

  assign mode.dev_sink_oe = sink_q;
  assign mode.pin_level   = v_q;

  // Normal mode needs the pin high and no protection active
  assign normal_ok = above_upper                               // [R3] [R12]
                   & ~sd_latch_q                               // [R9]
                   & (rc_q == apmc_pkg::RC_IDLE)               // [R6] [R8]
                   & ~sync2_q[apmc_pkg::IN_DC]                 // [R7]
                   & ~sync2_q[apmc_pkg::IN_OT]
                   & ~sync2_q[apmc_pkg::IN_TJ]                 // [R16]
                   & sync2_q[apmc_pkg::IN_AA_OK]
                   & sync2_q[apmc_pkg::IN_VCC_OK];             // [R17]

  // Bootstrap is needed to start but not to keep running
  assign run_d = normal_ok & (run_q | sync2_q[apmc_pkg::IN_BS_OK]);  // [R4] [R18]

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      run_q <= 1'b0;
    else
      run_q <= run_d;
  end

  // Mode outputs of the input amplifier section
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ota_en      <= 1'b0;
      o_prebias_osc <= 1'b0;
    end
    else
    begin
      o_ota_en      <= ~below_lower;                           // [R1]
      o_prebias_osc <= ~below_lower & ~above_upper;            // [R2]
    end
  end

  // Gate drive; both off outside normal mode
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pwm_run <= 1'b0;
      o_hs_on   <= 1'b0;
      o_ls_on   <= 1'b0;
    end
    else
    begin
      o_pwm_run <= run_d;                                      // [R3]
      o_hs_on   <= run_d & i_pwm_hs & sync2_q[apmc_pkg::IN_BS_OK];   // [R18]
      o_ls_on   <= run_d & i_pwm_ls & ~i_pwm_hs;               // [R17]
    end
  end

  // Fault flag released only while switching is allowed
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_fault_oe   <= 1'b1;
      o_sd_latched <= 1'b1;
    end
    else
    begin
      o_fault_oe   <= ~run_d;                                  // [R22] [R5]
      o_sd_latched <= sd_latch_q;
    end
  end

endmodule
`default_nettype wire

// File: verilog/apmc_host.sv
// Controller end: shutdown input, latch reset pulse and shutdown status detector
`timescale 1ns/10ps
`default_nettype none
module apmc_host #(
  parameter int PWRUP_WAIT = apmc_pkg::HOST_PWRUP_DEF   // Cycles before power-up pulse
) (
  input  wire logic   i_clk_sys,      // System clock
  input  wire logic   i_rst_n,        // Async reset, active low
  input  wire logic   i_shutdown,     // Hold amplifier in shutdown, level
  input  wire logic   i_reset_req,    // Request latch reset pulse, one cycle
  apmc_mode_if.host   mode,           // Mode-control pin
  output logic        o_sd_flag,      // Amplifier reports protection
  output logic        o_pulse_busy    // Reset pulse in progress
);

  logic [1:0]  det_q;      // Two-flop detector of the sink current
  logic [15:0] wait_q;     // Power-up wait counter
  logic        pwrup_q;    // Power-up pulse already issued
  logic [3:0]  pulse_q;    // Remaining pulse cycles
  logic        pull_q;     // Pull transistor drive

  // Sink detector crosses from the pin, so it is synchronised
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      det_q <= 2'b00;
    else
      det_q <= {det_q[0], mode.dev_sink_oe};                   // [R15]
  end

  // One automatic reset pulse after power-up for latched parts
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wait_q  <= '0;
      pwrup_q <= 1'b0;
    end
    else if (!pwrup_q)
    begin
      wait_q  <= wait_q + 16'h0001;
      pwrup_q <= (wait_q == 16'(PWRUP_WAIT - 1));              // [R14]
    end
  end

  // Pulse long enough to clear the latch after the amplifier samples it
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pulse_q <= '0;
    else if (i_reset_req || (!pwrup_q && wait_q == 16'(PWRUP_WAIT - 1)))
      pulse_q <= 4'(apmc_pkg::HOST_PULSE_CYC);                 // [R13] [R14]
    else if (pulse_q != 4'h0)
      pulse_q <= pulse_q - 4'h1;
  end

  // Pull the pin while shutdown is wanted or a pulse runs
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pull_q <= 1'b0;
    else
      pull_q <= i_shutdown | (pulse_q > 4'h1) | i_reset_req;   // [R12]
  end

  assign mode.host_pull_oe = pull_q;

  // Status outputs
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_sd_flag    <= 1'b0;
      o_pulse_busy <= 1'b0;
    end
    else
    begin
      o_sd_flag    <= det_q[1];
      o_pulse_busy <= (pulse_q != 4'h0);
    end
  end

endmodule
`default_nettype wire

// File: verification/apmc_monitor.sv
// Concurrent checks on the mode-control pin and both ends
`timescale 1ns/10ps
`default_nettype none
module apmc_monitor (
  input wire logic i_clk_sys,      // System clock
  input wire logic i_rst_n,        // Async reset, active low
  input wire logic dev_sink_oe,    // Amplifier sinks the pin
  input wire logic host_pull_oe,   // Controller pulls the pin
  input wire logic i_cfg_latched,  // Latched protection mode
  input wire logic i_oc_hs,        // High-side overcurrent
  input wire logic i_oc_ls,        // Low-side overcurrent
  input wire logic i_tj_hot,       // Junction too hot
  input wire logic i_dc_fault,     // DC offset fault
  input wire logic i_vcc_ok,       // Gate supply ok
  input wire logic i_bs_ok,        // Bootstrap supply ok
  input wire logic o_ota_en,       // Input amplifier on
  input wire logic o_prebias_osc,  // Prebias oscillation on
  input wire logic o_pwm_run,      // Switching allowed
  input wire logic o_hs_on,        // High-side gate
  input wire logic o_ls_on,        // Low-side gate
  input wire logic o_fault_oe,     // Fault flag pulled
  input wire logic o_sd_latched,   // Shutdown latch
  input wire logic o_sd_flag,      // Controller status flag
  input wire logic o_pulse_busy    // Reset pulse running
);
  default clocking mon_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  // Either current sensor trips
  sequence oc_trip;
    i_oc_hs || i_oc_ls;
  endsequence
  // Host holds the pin low long enough, with no overcurrent competing
  sequence long_pull;
    (i_cfg_latched && host_pull_oe && !i_oc_hs && !i_oc_ls) [*5];
  endsequence

  run_flag_a: assert property ((dev_sink_oe || o_sd_latched) |-> o_fault_oe && !o_pwm_run)
    else $error("fault flag released during protection");
  oc_latch_a: assert property (oc_trip |-> ##[1:5] o_sd_latched)
    else $error("overcurrent did not set latch");
  latch_off_a: assert property ($rose(o_sd_latched) |-> ##[0:2] !o_pwm_run)
    else $error("switching after latch set");
  dc_hold_a: assert property (i_dc_fault [*6] |-> dev_sink_oe && o_fault_oe)
    else $error("dc fault not holding pin");
  vcc_off_a: assert property (!i_vcc_ok [*5] |-> !o_hs_on && !o_ls_on)
    else $error("gates on with gate supply low");
  bs_hs_a: assert property (!i_bs_ok [*5] |-> !o_hs_on)
    else $error("high side on with bootstrap low");
  tj_stop_a: assert property (i_tj_hot [*5] |-> !o_pwm_run)
    else $error("switching while junction hot");
  prebias_mode_a: assert property (o_prebias_osc |-> o_ota_en && !o_pwm_run)
    else $error("prebias outside start-up band");
  gate_run_a: assert property ((o_hs_on || o_ls_on) |-> o_pwm_run)
    else $error("gate on outside normal mode");
  pulse_len_a: assert property ($rose(o_pulse_busy) |-> host_pull_oe [*4])
    else $error("reset pulse too short");
  latch_clr_a: assert property (long_pull |-> ##[0:3] !o_sd_latched)
    else $error("latch not cleared by pull");
  sink_flag_a: assert property (dev_sink_oe [*5] |-> o_sd_flag)
    else $error("sink not reported to controller");
endmodule
`default_nettype wire

// File: verification/amp_protection_mode_control_tb.sv
// Self-checking bench joining the amplifier end and the controller end
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
`define WAITFOR(c) begin k = 0; while (!(c) && k < 3000) begin cyc(1); k++; end \
  `CHK("wait", 1'b1, k < 3000) end
module amp_protection_mode_control_tb;
  logic i_clk_sys, i_rst_n, i_cfg_latched, i_oc_hs, i_oc_ls; // Clock, reset, sensors
  logic i_ot_evt, i_tj_hot, i_dc_fault, i_aa_ok, i_vcc_ok;    // Events, supplies
  logic i_bs_ok, i_pwm_hs, i_pwm_ls, i_shutdown, i_reset_req; // Modulator, host
  logic o_ota_en, o_prebias_osc, o_pwm_run, o_hs_on, o_ls_on; // Amplifier outputs
  logic o_fault_oe, o_sd_latched, o_sd_flag, o_pulse_busy;    // Flags
  int   miscompares, n_checks, k, lsn, su;                    // Counters
  apmc_mode_if mode_if ();                                    // Pin carrier
  // Low side asks whenever high side does not
  assign i_pwm_ls = ~i_pwm_hs;

  // Fast stand-in for the timing capacitor; the ramp still crosses the band gradually
  localparam int RAMP_TB = 2;

  apmc_device #(.RAMP_TICK(RAMP_TB)) apmc_device_i (.i_clk_sys, .i_rst_n, .i_cfg_latched,
    .i_oc_hs, .i_oc_ls, .i_ot_evt, .i_tj_hot, .i_dc_fault, .i_aa_ok, .i_vcc_ok, .i_bs_ok,
    .i_pwm_hs, .i_pwm_ls, .mode(mode_if), .o_ota_en, .o_prebias_osc, .o_pwm_run,
    .o_hs_on, .o_ls_on, .o_fault_oe, .o_sd_latched);
  apmc_host #(.PWRUP_WAIT(8)) apmc_host_i (.i_clk_sys, .i_rst_n, .i_shutdown,
    .i_reset_req, .mode(mode_if), .o_sd_flag, .o_pulse_busy);
  apmc_monitor apmc_monitor_i (.i_clk_sys, .i_rst_n, .dev_sink_oe(mode_if.dev_sink_oe),
    .host_pull_oe(mode_if.host_pull_oe), .i_cfg_latched, .i_oc_hs, .i_oc_ls, .i_tj_hot,
    .i_dc_fault, .i_vcc_ok, .i_bs_ok, .o_ota_en, .o_prebias_osc, .o_pwm_run, .o_hs_on,
    .o_ls_on, .o_fault_oe, .o_sd_latched, .o_sd_flag, .o_pulse_busy);

  // Free-running system clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  // Modulator alternates sides, so both gates get exercised
  always @(posedge i_clk_sys) i_pwm_hs <= #5 ~i_pwm_hs;

  // Step whole cycles, landing just after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #5;
  endtask

  // Counts, verdict and end of run
  task automatic finish_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard, far beyond the few thousand cycles expected
  initial
  begin
    #(50 * 40000);
    miscompares++;
    finish_test();
  end

  initial
  begin
    {i_rst_n, i_cfg_latched, i_oc_hs, i_oc_ls, i_ot_evt, i_tj_hot} = '0;
    {i_dc_fault, i_shutdown, i_reset_req, i_pwm_hs} = '0;
    {i_aa_ok, i_vcc_ok, i_bs_ok} = 3'b111;
    miscompares = 0;
    n_checks = 0;
    cyc(16);
    i_rst_n = 1'b1;
    `CHK("fault at reset", 1'b1, o_fault_oe)
    `WAITFOR(o_prebias_osc === 1'b1)
    `CHK("ota in band", 2'b10, {o_ota_en, o_pwm_run})
    // Band crossing time at the start-up rate, compared with a recycle later
    `WAITFOR(o_pwm_run === 1'b1)
    su = k;
    `CHK("run", 1'b1, o_pwm_run)
    `CHK("level", 1'b1, mode_if.pin_level > apmc_pkg::V_UPPER)
    $display("test startup done");
    // Controller forces shutdown, pin falls through both bands
    i_shutdown = 1'b1;
    `WAITFOR(o_ota_en === 1'b0)
    `CHK("shut ota", 3'b000, {o_ota_en, o_prebias_osc, o_pwm_run})
    i_shutdown = 1'b0;
    `WAITFOR(o_pwm_run === 1'b1)
    `CHK("resume", 1'b1, o_pwm_run)
    $display("test shutdown done");
    // Persistent overcurrent keeps the pin recycling
    i_oc_hs = 1'b1;
    cyc(7);
    `CHK("oc latch", 1'b1, o_sd_latched)
    `CHK("oc sink", 1'b1, mode_if.dev_sink_oe)
    `WAITFOR(mode_if.dev_sink_oe === 1'b0)
    `WAITFOR(mode_if.dev_sink_oe === 1'b1)
    `CHK("recycle", 3'b110, {mode_if.dev_sink_oe, o_fault_oe, o_pwm_run})
    i_oc_hs = 1'b0;
    `WAITFOR(o_pwm_run === 1'b1)
    `CHK("oc clear", 2'b01, {o_sd_latched, o_pwm_run})
    $display("test overcurrent done");
    // DC fault holds pin and flag
    i_dc_fault = 1'b1;
    cyc(8);
    `CHK("dc hold", 3'b110, {mode_if.dev_sink_oe, o_fault_oe, o_pwm_run})
    cyc(6);
    `CHK("dc flag", 1'b1, o_sd_flag)
    i_dc_fault = 1'b0;
    `WAITFOR(o_pwm_run === 1'b1)
    $display("test dc done");
    // High side switches on every other cycle while the bootstrap is good
    lsn = 0;
    repeat (8)
    begin
      cyc(1);
      lsn += (o_hs_on === 1'b1);
    end
    `CHK("hs runs", 4, lsn)
    // Bootstrap loss blocks only the high side
    i_bs_ok = 1'b0;
    cyc(6);
    lsn = 0;
    repeat (8)
    begin
      cyc(1);
      `CHK("hs blocked", 1'b0, o_hs_on)
      lsn += (o_ls_on === 1'b1);
    end
    `CHK("ls runs", 4, lsn)
    i_bs_ok = 1'b1;
    // Gate supply loss, then recovery recycles the pin
    i_vcc_ok = 1'b0;
    cyc(6);
    `CHK("vcc off", 3'b001, {o_hs_on, o_ls_on, o_fault_oe})
    i_vcc_ok = 1'b1;
    cyc(7);
    `CHK("vcc recycle", 2'b11, {mode_if.dev_sink_oe, o_fault_oe})
    // Recycle charge crosses the band faster than the first start-up
    `WAITFOR(o_ota_en === 1'b0)
    `WAITFOR(o_prebias_osc === 1'b1)
    `WAITFOR(o_pwm_run === 1'b1)
    `CHK("start slower", 1'b1, su > k)
    // Analog supply low stops switching
    i_aa_ok = 1'b0;
    cyc(6);
    `CHK("aa low", 2'b01, {o_pwm_run, o_fault_oe})
    i_aa_ok = 1'b1;
    `WAITFOR(o_pwm_run === 1'b1)
    // Junction overheat, then over-temperature input
    i_tj_hot = 1'b1;
    cyc(6);
    `CHK("tj stop", 1'b0, o_pwm_run)
    i_tj_hot = 1'b0;
    i_ot_evt = 1'b1;
    cyc(7);
    `CHK("ot recycle", 2'b11, {mode_if.dev_sink_oe, o_fault_oe})
    i_ot_evt = 1'b0;
    `WAITFOR(o_pwm_run === 1'b1)
    `CHK("recovered", 1'b1, o_pwm_run)
    $display("test supplies done");
    // Latched mode: power-up pulse, overcurrent, manual reset
    i_rst_n = 1'b0;
    i_cfg_latched = 1'b1;
    cyc(2);
    i_rst_n = 1'b1;
    cyc(4);
    `CHK("pwrup shut", 2'b10, {o_sd_latched, o_pwm_run})
    `WAITFOR(o_pwm_run === 1'b1)
    `CHK("pwrup clear", 1'b0, o_sd_latched)
    i_oc_ls = 1'b1;
    cyc(4);
    i_oc_ls = 1'b0;
    cyc(30);
    `CHK("stays shut", 3'b101, {o_sd_latched, o_pwm_run, o_sd_flag})
    i_reset_req = 1'b1;
    cyc(1);
    i_reset_req = 1'b0;
    `WAITFOR(o_pulse_busy === 1'b0)
    `WAITFOR(o_pwm_run === 1'b1)
    `CHK("latch reset", 2'b01, {o_sd_latched, o_pwm_run})
    $display("test latched done");
    finish_test();
  end
endmodule
`default_nettype wire
